/* core/pcp_pkg.sv */
// constants, field layout and carrier types of the clock control block
// assumes a 20 MHz source clock on clk_i and a synchronous register port
package pcp_pkg;

    // register map, word index on the plain register port
    localparam logic [3:0] REG_PLL_CTRL_STATUS = 4'h0;
    localparam logic [3:0] REG_CLK_DIV_CTRL    = 4'h1;

    // pll_control_status fields
    localparam int PLL_LOCKED_BIT = 0;
    localparam int PLL_ENABLE_BIT = 1;
    localparam int PLL_RATE_BIT   = 2;

    // clock_divider_control fields
    localparam int          DIV_CHANGE_EN_BIT = 7;
    localparam logic [7:0]  DIV_UNLOCK_WORD   = 8'h80;
    localparam logic [3:0]  DIV_SEL_RESET     = 4'h0;
    localparam logic [3:0]  DIV_SEL_RESET_DIV8 = 4'h3;
    localparam logic [3:0]  DIV_SEL_MAX       = 4'h8;
    localparam logic [2:0]  DIV_CHANGE_WINDOW = 3'h4;

    // fuse codes
    localparam logic [3:0] SRC_EXT_CLOCK = 4'h0;
    localparam logic [3:0] SRC_PLL_RC    = 4'h3;
    localparam logic [3:0] SRC_PLL_EXT   = 4'h5;
    localparam logic [1:0] SUT_SHORT     = 2'h0;
    localparam logic [1:0] SUT_FAST      = 2'h1;
    localparam logic [1:0] SUT_SLOW      = 2'h2;

    // pll output rates in MHz, from a 1 MHz reference
    localparam logic [6:0] PLL_MHZ_HIGH = 7'h40;
    localparam logic [6:0] PLL_MHZ_LOW  = 7'h20;

    // timing
    localparam int CLK_HZ           = 20_000_000;
    localparam int CYC_PER_US       = CLK_HZ / 1_000_000;
    localparam int LOCK_TIME_US     = 100_000;
    localparam int LOCK_CYCLES      = LOCK_TIME_US * CYC_PER_US;
    localparam int SUT_FAST_US_X10  = 41_000;
    localparam int SUT_FAST_CYCLES  = SUT_FAST_US_X10 * CYC_PER_US / 10;
    localparam int SUT_SLOW_US      = 65_000;
    localparam int SUT_SLOW_CYCLES  = SUT_SLOW_US * CYC_PER_US;
    localparam int RESET_CK         = 14;
    localparam int WAKE_CK          = 6;
    localparam int CNT_W            = 21;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pcp_bus_req_s;

    typedef struct packed {
        logic [3:0] clock_source;
        logic [1:0] startup_time;
        logic       clock_output;
        logic       divide_by_eight;
    } pcp_fuse_s;

endpackage

/* core/pcp_clock_ctrl.sv */
// pll control, start-up delay, clock output buffer and system clock prescaler
// assumes fuses are stable while rst_i is high and the bus master obeys the
// one-cycle strobe protocol; the analogue pll and gating cells sit outside
//
// Contract
// - reserved pll register bits 7..3 read as zero.
// - rate select one gives 64 MHz, zero gives 32 MHz.
// - pll enable starts the pll and its rc reference oscillator.
// - pll enable reads one whenever the pll is the system clock source.
// - lock flag sets after the lock time once the pll is enabled.
// - clock source fuses 0000 select the external clock input.
// - start-up delay 6 CK from power-down, 14CK plus fuse-chosen extra from reset.
// - clock output fuse drives system clock on its pin, also in reset; here the pin is held high in reset.
// - clock output pin carries the divided system clock.
// - one prescaler divides processor, io, converter and flash clocks together.
// - divider change gives no glitch and no period shorter than both.
// - new rate starts after the old period ends, two edges meanwhile.
// - change enable updates only when all other bits are written zero.
// - change enable clears four cycles after setting or on select write.
// - rewriting change enable in its window neither extends nor clears it.
// - select resets to 0000, or 0011 with the divide-by-eight fuse.
// - select accepts any value at run time.
// - select n divides by two to the n, up to 256.
// - pll multiplies a 1 MHz rc-derived reference by 64.
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module pcp_clock_ctrl #(
    parameter int LOCK_CYCLES     = pcp_pkg::LOCK_CYCLES,
    parameter int SUT_FAST_CYCLES = pcp_pkg::SUT_FAST_CYCLES,
    parameter int SUT_SLOW_CYCLES = pcp_pkg::SUT_SLOW_CYCLES
) (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // register port
    input  wire pcp_pkg::pcp_bus_req_s bus_i,
    output logic [7:0]                rdata_o,
    // fuses and power-down wake request
    input  wire pcp_pkg::pcp_fuse_s   fuse_i,
    input  wire logic                 wake_i,
    // pll and oscillator control
    output logic                      pll_run_o,
    output logic                      rc_osc_run_o,
    output logic [6:0]                pll_freq_mhz_o,
    output logic                      pll_locked_o,
    output logic                      ext_clk_select_o,
    // system clock
    output logic                      sys_ready_o,
    output logic                      sys_tick_o,
    output logic                      clock_output_pin_o,
    output logic                      clock_output_oe_n_o
);

    typedef enum logic [1:0] {
        ST_RESET_WAIT,
        ST_RUN,
        ST_WAKE_WAIT
    } pcp_start_e;

    // fuse copies caught while reset is held
    pcp_pkg::pcp_fuse_s fuse_reg;

    // pll state
    logic                         pll_rate_reg;
    logic                         pll_en_reg;
    logic                         pll_lock_reg;
    logic [pcp_pkg::CNT_W-1:0]    lock_cnt_reg;
    logic [pcp_pkg::CNT_W-1:0]    lock_cnt_next;

    // prescaler state
    logic                         ce_reg;
    logic [2:0]                   ce_cnt_reg;
    logic [3:0]                   sel_reg;
    logic [3:0]                   sel_act_reg;
    logic [7:0]                   div_cnt_reg;

    // start-up state
    pcp_start_e                   st_reg;
    logic [pcp_pkg::CNT_W-1:0]    st_cnt_reg;

    // output flops
    logic [7:0]                   rdata_reg;
    logic                         tick_reg;
    logic                         clkout_reg;
    logic                         oe_n_reg;

    // decode
    wire logic wr_pll    = bus_i.wr && (bus_i.addr == pcp_pkg::REG_PLL_CTRL_STATUS);
    wire logic wr_div    = bus_i.wr && (bus_i.addr == pcp_pkg::REG_CLK_DIV_CTRL);
    wire logic rd_pll    = bus_i.rd && (bus_i.addr == pcp_pkg::REG_PLL_CTRL_STATUS);
    wire logic rd_div    = bus_i.rd && (bus_i.addr == pcp_pkg::REG_CLK_DIV_CTRL);
    wire logic pll_sys   = (fuse_reg.clock_source == pcp_pkg::SRC_PLL_RC) ||
                           (fuse_reg.clock_source == pcp_pkg::SRC_PLL_EXT);
    // enable already reads one in reset when the pll will clock the core
    wire logic pll_sys_fuse = (fuse_i.clock_source == pcp_pkg::SRC_PLL_RC) ||
                              (fuse_i.clock_source == pcp_pkg::SRC_PLL_EXT);
    wire logic ce_wbit   = bus_i.wdata[pcp_pkg::DIV_CHANGE_EN_BIT];
    // only the exact unlock word arms the change window
    wire logic ce_set    = wr_div && (bus_i.wdata == pcp_pkg::DIV_UNLOCK_WORD) && !ce_reg;
    wire logic sel_wr    = wr_div && ce_reg && !ce_wbit;
    wire logic ce_expire = ce_reg && (ce_cnt_reg == 3'h1);

    // pll enable is forced while the pll clocks the core
    wire logic pll_en_next = pll_sys ? 1'b1 :
                             wr_pll  ? bus_i.wdata[pcp_pkg::PLL_ENABLE_BIT] : pll_en_reg;
    wire logic pll_lock_hit = pll_en_reg && (lock_cnt_reg == LOCK_CYCLES[pcp_pkg::CNT_W-1:0]);
    assign lock_cnt_next = !pll_en_reg ? '0 :
                           pll_lock_hit ? lock_cnt_reg : lock_cnt_reg + 1'b1;

    // readback
    wire logic [7:0] pll_rd_word = {5'h00, pll_rate_reg, pll_en_reg, pll_lock_reg};
    wire logic [7:0] div_rd_word = {ce_reg, 3'h0, sel_reg};
    wire logic [7:0] rdata_next  = rd_pll ? pll_rd_word :
                                   rd_div ? div_rd_word : 8'h00;

    // reserved codes above 8 saturate at the slowest rate, divide by 256
    wire logic [3:0] sel_eff     = (sel_reg > pcp_pkg::DIV_SEL_MAX) ?
                                   pcp_pkg::DIV_SEL_MAX : sel_reg;
    wire logic [8:0] div_len     = 9'h001 << sel_eff;
    wire logic [8:0] act_len     = 9'h001 << sel_act_reg;
    wire logic       div_wrap    = (div_cnt_reg == 8'h00);
    // the old period always completes before the new length is taken
    wire logic [7:0] div_reload  = 8'(div_len - 9'h001);

    // start-up extra delay chosen by the start-up fuses
    wire logic [pcp_pkg::CNT_W-1:0] sut_extra =
        (fuse_reg.startup_time == pcp_pkg::SUT_FAST) ? SUT_FAST_CYCLES[pcp_pkg::CNT_W-1:0] :
        (fuse_reg.startup_time == pcp_pkg::SUT_SLOW) ? SUT_SLOW_CYCLES[pcp_pkg::CNT_W-1:0] :
        '0;
    wire logic [pcp_pkg::CNT_W-1:0] reset_len = pcp_pkg::CNT_W'(pcp_pkg::RESET_CK) + sut_extra;
    wire logic [pcp_pkg::CNT_W-1:0] wake_len  = pcp_pkg::CNT_W'(pcp_pkg::WAKE_CK);

    // fuses sampled during reset, the register reset values depend on them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fuse_reg <= fuse_i;
        end
    end

    // pll control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pll_rate_reg <= 1'b0;
            pll_en_reg   <= pll_sys_fuse;
            pll_lock_reg <= 1'b0;
            lock_cnt_reg <= '0;
        end else begin
            if (wr_pll) begin
                pll_rate_reg <= bus_i.wdata[pcp_pkg::PLL_RATE_BIT];
            end
            pll_en_reg   <= pll_en_next;
            lock_cnt_reg <= lock_cnt_next;
            pll_lock_reg <= pll_lock_hit;
        end
    end

    // change window of the prescaler select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ce_reg     <= 1'b0;
            ce_cnt_reg <= 3'h0;
        end else if (ce_set) begin
            ce_reg     <= 1'b1;
            ce_cnt_reg <= pcp_pkg::DIV_CHANGE_WINDOW;
        end else if (sel_wr || ce_expire) begin
            ce_reg     <= 1'b0;
            ce_cnt_reg <= 3'h0;
        end else if (ce_reg) begin
            ce_cnt_reg <= ce_cnt_reg - 3'h1;
        end
    end

    // prescaler select, reset value from the divide-by-eight fuse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_reg <= fuse_i.divide_by_eight ? pcp_pkg::DIV_SEL_RESET_DIV8 :
                                                 pcp_pkg::DIV_SEL_RESET;
        end else if (sel_wr) begin
            sel_reg <= bus_i.wdata[3:0];
        end
    end

    // one divider feeds every core clock, so they stay in step
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt_reg <= 8'h00;
            sel_act_reg <= pcp_pkg::DIV_SEL_RESET;
        end else if (div_wrap) begin
            div_cnt_reg <= div_reload;
            sel_act_reg <= sel_eff;
        end else begin
            div_cnt_reg <= div_cnt_reg - 8'h01;
        end
    end

    // start-up delay after reset and after power-down wake
    // limitation: the wake delay is the short one for every clock source
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg     <= ST_RESET_WAIT;
            st_cnt_reg <= '0;
        end else begin
            case (st_reg)
                ST_RESET_WAIT: begin
                    if (st_cnt_reg + 1'b1 >= reset_len) begin
                        st_reg     <= ST_RUN;
                        st_cnt_reg <= '0;
                    end else begin
                        st_cnt_reg <= st_cnt_reg + 1'b1;
                    end
                end
                ST_RUN: begin
                    if (wake_i) begin
                        st_reg     <= ST_WAKE_WAIT;
                        st_cnt_reg <= '0;
                    end
                end
                ST_WAKE_WAIT: begin
                    if (st_cnt_reg + 1'b1 >= wake_len) begin
                        st_reg     <= ST_RUN;
                        st_cnt_reg <= '0;
                    end else begin
                        st_cnt_reg <= st_cnt_reg + 1'b1;
                    end
                end
                default: begin
                    st_reg     <= ST_RESET_WAIT;
                    st_cnt_reg <= '0;
                end
            endcase
        end
    end

    // output flops; in reset the pin is held high and does not toggle, while
    // its output enable already follows the clock output fuse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg  <= 8'h00;
            tick_reg   <= 1'b1;
            clkout_reg <= 1'b1;
            oe_n_reg   <= !fuse_i.clock_output;
        end else begin
            rdata_reg  <= rdata_next;
            tick_reg   <= div_wrap;
            clkout_reg <= div_wrap;
            oe_n_reg   <= !fuse_reg.clock_output;
        end
    end

    assign rdata_o             = rdata_reg;
    assign pll_run_o           = pll_en_reg;
    assign rc_osc_run_o        = pll_en_reg;
    // the pll multiplies the 1 MHz rc reference by 64, halved on the low rate
    assign pll_freq_mhz_o      = pll_rate_reg ? pcp_pkg::PLL_MHZ_HIGH :
                                                pcp_pkg::PLL_MHZ_LOW;
    assign pll_locked_o        = pll_lock_reg;
    assign ext_clk_select_o    = (fuse_reg.clock_source == pcp_pkg::SRC_EXT_CLOCK);
    assign sys_ready_o         = (st_reg == ST_RUN);
    assign sys_tick_o          = tick_reg;
    assign clock_output_pin_o  = clkout_reg;
    assign clock_output_oe_n_o = oe_n_reg;

    // helper: cycles between divider wraps
    logic [8:0] gap_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap_reg <= 9'h001;
        end else begin
            gap_reg <= div_wrap ? 9'h001 : gap_reg + 9'h001;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_arm;
        $rose(ce_reg);
    endsequence

    sequence s_quiet3;
        (!sel_wr)[*3];
    endsequence

    sequence s_wake_hold;
        (!sys_ready_o)[*6] ##1 sys_ready_o;
    endsequence

    AST_RESERVED_ZERO: assert property (
        $past(rd_pll) |-> (rdata_o[7:3] == 5'h00))
        else $error("reserved pll bits read nonzero");

    AST_PLL_RATE: assert property (
        $past(wr_pll) |-> (pll_freq_mhz_o ==
            ($past(bus_i.wdata[2]) ? 7'h40 : 7'h20)))
        else $error("pll rate does not follow select bit");

    AST_PLL_START: assert property (
        $past(wr_pll && bus_i.wdata[1]) |-> (pll_run_o && rc_osc_run_o))
        else $error("pll enable did not start pll and reference");

    AST_PLL_FORCED: assert property (
        ##1 pll_sys |-> pll_run_o)
        else $error("pll enable low while pll is system clock");

    AST_LOCK_AFTER_ENABLE: assert property (
        $rose(pll_locked_o) |-> ($past(pll_run_o) && $past(lock_cnt_reg) ==
            LOCK_CYCLES[pcp_pkg::CNT_W-1:0]))
        else $error("lock flag set before the lock time");

    AST_LOCK_DROP: assert property (
        !pll_run_o |=> !pll_locked_o)
        else $error("lock flag stayed with pll stopped");

    AST_CE_TIMEOUT: assert property (
        s_arm ##0 s_quiet3 ##1 !sel_wr |=> !ce_reg)
        else $error("change enable not cleared after four cycles");

    AST_CE_NO_EXTEND: assert property (
        (ce_reg && wr_div && ce_wbit) |=>
            (ce_cnt_reg == $past(ce_cnt_reg) - 3'h1) && (ce_reg == (ce_cnt_reg != 3'h0)))
        else $error("change enable window lost or restarted");

    AST_CE_CLEAN_ONLY: assert property (
        (wr_div && !ce_reg && bus_i.wdata != 8'h80) |=> !ce_reg)
        else $error("change enable set by a dirty write");

    AST_SEL_LOAD: assert property (
        sel_wr |=> (sel_reg == $past(bus_i.wdata[3:0])) && !ce_reg)
        else $error("select write not taken or window left open");

    AST_SEL_LOCKED: assert property (
        (wr_div && !ce_reg) |=> $stable(sel_reg))
        else $error("select changed without change enable");

    AST_FUSE_RESET: assert property (
        $past(rst_i) |-> (sel_reg == (fuse_reg.divide_by_eight ? 4'h3 : 4'h0)))
        else $error("select reset value wrong");

    AST_NO_SHORT_PERIOD: assert property (
        div_wrap |-> (gap_reg == act_len))
        else $error("divider period shorter than allowed");

    AST_CLKOUT_OE: assert property (
        ##1 (oe_n_reg == !fuse_reg.clock_output))
        else $error("clock output enable does not follow fuse");

    AST_CE_ARM: assert property (
        (wr_div && !ce_reg && bus_i.wdata == pcp_pkg::DIV_UNLOCK_WORD) |=>
            (ce_reg && ce_cnt_reg == pcp_pkg::DIV_CHANGE_WINDOW))
        else $error("clean unlock write did not open the window");

    AST_LOCK_HOLD: assert property (
        (pll_run_o && pll_locked_o) |=> pll_locked_o)
        else $error("lock flag dropped while pll enabled");

    AST_WAKE_DELAY: assert property (
        (sys_ready_o && wake_i) |=> s_wake_hold)
        else $error("power-down wake delay wrong");

    AST_PIN_DIVIDED: assert property (
        clock_output_pin_o == sys_tick_o)
        else $error("clock output pin not the divided clock");

    AST_RATE_HOLD: assert property (
        !wr_pll |=> $stable(pll_freq_mhz_o))
        else $error("pll rate changed without a write");

    AST_SEL_RESERVED: assert property (
        (div_wrap && sel_reg > pcp_pkg::DIV_SEL_MAX) |=> (sel_act_reg == pcp_pkg::DIV_SEL_MAX))
        else $error("reserved select code not at the slowest rate");

endmodule

`default_nettype wire

/* sim/pcp_partner.sv */
// partner model: fuse block and the power stage clock gate around the clock control
// assumes cfg_i is only changed by the bench while rst_i is high
`timescale 1ns/1ns
`default_nettype none

module pcp_partner (
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // wanted fuse values and pll status
    input  wire pcp_pkg::pcp_fuse_s cfg_i,
    input  wire logic               locked_i,
    input  wire logic               want_pll_i,
    // fuses and pll clock gate
    output var pcp_pkg::pcp_fuse_s  fuse_o,
    output logic                    route_pll_o
);
    // fuses only move in reset, so the source never jumps while running
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fuse_o <= cfg_i;
        end
        // the power stages get the fast clock only once lock is reported
        route_pll_o <= want_pll_i && locked_i && !rst_i;
    end
endmodule

`default_nettype wire

/* sim/pcp_clock_ctrl_tb.sv */
// self-checking bench for the clock control block
// assumes pcp_pkg, pcp_clock_ctrl and pcp_partner are compiled before it
`timescale 1ns/1ns
`default_nettype none

module pcp_clock_ctrl_tb;
    localparam int LOCK_N = 20;
    localparam int FAST_N = 10;
    localparam int SLOW_N = 30;
    localparam logic [3:0] PLL = pcp_pkg::REG_PLL_CTRL_STATUS;
    localparam logic [3:0] DIV = pcp_pkg::REG_CLK_DIV_CTRL;

    logic                  clk_i, rst_i, wake_i, want_pll, route_pll, watch;
    pcp_pkg::pcp_bus_req_s bus_i;
    pcp_pkg::pcp_fuse_s    cfg, fuse;
    logic [7:0]            rdata_o, rd_val;
    logic [6:0]            freq;
    logic                  run, rc_run, locked, ext_sel, ready, tick, pin, oe_n;
    int                    errors, samples_checked, cycles, gap, min_gap;

    pcp_clock_ctrl #(
        .LOCK_CYCLES    (LOCK_N),
        .SUT_FAST_CYCLES(FAST_N),
        .SUT_SLOW_CYCLES(SLOW_N)
    ) i_pcp_clock_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .fuse_i(fuse), .wake_i(wake_i), .pll_run_o(run), .rc_osc_run_o(rc_run),
        .pll_freq_mhz_o(freq), .pll_locked_o(locked), .ext_clk_select_o(ext_sel),
        .sys_ready_o(ready), .sys_tick_o(tick), .clock_output_pin_o(pin),
        .clock_output_oe_n_o(oe_n)
    );

    pcp_partner i_pcp_partner (
        .clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg), .locked_i(locked),
        .want_pll_i(want_pll), .fuse_o(fuse), .route_pll_o(route_pll)
    );

    always #25 clk_i = ~clk_i;

    // gap between divided ticks, watched across a divider change
    always @(posedge clk_i) begin
        cycles++;
        gap++;
        if (tick === 1'b1) begin
            if (watch && gap < min_gap) begin
                min_gap = gap;
            end
            gap = 0;
        end
        if (cycles == 30000) begin
            errors++;
            test_done();
        end
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_i.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_i.rd <= 1'b0;
        #1;
        rd_val = rdata_o;
    endtask

    task automatic set_div(input logic [3:0] s);
        wr(DIV, pcp_pkg::DIV_UNLOCK_WORD);
        wr(DIV, {4'h0, s});
    endtask

    task automatic tick_gap(output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (tick !== 1'b1 && n < 600);
    endtask

    task automatic do_reset(input pcp_pkg::pcp_fuse_s f, input int extra);
        int n;
        @(posedge clk_i);
        rst_i <= 1'b1;
        cfg <= f;
        repeat (10) @(posedge clk_i);
        #1;
        chk("pin_in_reset", 16'(pin), 16'h1);
        chk("oe_n_in_reset", 16'(oe_n), 16'(!f.clock_output));
        @(posedge clk_i);
        rst_i <= 1'b0;
        n = 0;
        while (ready !== 1'b1 && n < 2000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("startup", 16'(n), 16'(14 + extra));
    endtask

    task automatic t_startup;
        int xtra [3];
        xtra = '{0, FAST_N, SLOW_N};
        for (int s = 0; s < 3; s++) begin
            do_reset('{clock_source: pcp_pkg::SRC_EXT_CLOCK, startup_time: 2'(s),
                       clock_output: s[0], divide_by_eight: s[0]}, xtra[s]);
            chk("ext_select", 16'(ext_sel), 16'h1);
            rd(DIV);
            chk("div_reset", 16'(rd_val), s[0] ? 16'h3 : 16'h0);
            rd(PLL);
            chk("pll_reset", 16'(rd_val), 16'h0);
        end
    endtask

    task automatic t_pll;
        int n;
        wr(PLL, 8'hFF);
        #1;
        chk("pll_run", 16'(run), 16'h1);
        chk("rc_run", 16'(rc_run), 16'h1);
        chk("pll_mhz", 16'(freq), 16'(pcp_pkg::PLL_MHZ_HIGH));
        n = 0;
        while (locked !== 1'b1 && n < 200) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("lock_time", 16'(n), 16'(LOCK_N + 1));
        want_pll <= 1'b1;
        rd(PLL);
        chk("pll_status", 16'(rd_val), 16'h7);
        chk("route", 16'(route_pll), 16'h1);
        wr(PLL, 8'h00);
        want_pll <= 1'b0;
        #1;
        chk("pll_stop", 16'(run), 16'h0);
        chk("pll_mhz_low", 16'(freq), 16'(pcp_pkg::PLL_MHZ_LOW));
        rd(PLL);
        chk("pll_cleared", 16'(rd_val), 16'h0);
    endtask

    task automatic t_pll_source;
        logic [3:0] src [2];
        src = '{pcp_pkg::SRC_PLL_EXT, pcp_pkg::SRC_PLL_RC};
        for (int k = 0; k < 2; k++) begin
            do_reset('{clock_source: src[k], startup_time: pcp_pkg::SUT_SHORT,
                       clock_output: 1'b1, divide_by_eight: 1'b1}, 0);
            wr(PLL, 8'h00);
            rd(PLL);
            chk("pll_forced", 16'(rd_val & 8'h02), 16'h2);
            chk("ext_select_off", 16'(ext_sel), 16'h0);
        end
    endtask

    // reserved codes are kept and divide like the largest factor
    task automatic t_divider;
        int n;
        for (int s = 0; s < 10; s++) begin
            set_div(4'(s));
            rd(DIV);
            chk("div_sel", 16'(rd_val), 16'(s));
            repeat (4) tick_gap(n);
            chk("div_period", 16'(n), 16'(1 << (s > 8 ? 8 : s)));
            chk("pin_follows", 16'(pin), 16'h1);
            @(posedge clk_i);
            #1;
            chk("pin_low", 16'(pin), (s == 0) ? 16'h1 : 16'h0);
            chk("oe_n_run", 16'(oe_n), 16'h0);
        end
    endtask

    task automatic t_protect;
        set_div(4'h1);
        wr(DIV, 8'h81);
        wr(DIV, 8'h05);
        rd(DIV);
        chk("no_arm", 16'(rd_val), 16'h1);
        wr(DIV, 8'h80);
        repeat (4) @(posedge clk_i);
        wr(DIV, 8'h05);
        rd(DIV);
        chk("expired", 16'(rd_val), 16'h1);
        wr(DIV, 8'h80);
        wr(DIV, 8'h80);
        rd(DIV);
        chk("rearm_kept", 16'(rd_val), 16'h81);
        wr(DIV, 8'h05);
        rd(DIV);
        chk("rearm_no_extend", 16'(rd_val), 16'h1);
    endtask

    task automatic t_glitch;
        int n;
        set_div(4'h3);
        repeat (3) tick_gap(n);
        min_gap = 999;
        watch = 1'b1;
        set_div(4'h1);
        repeat (6) tick_gap(n);
        watch = 1'b0;
        chk("min_gap", 16'(min_gap), 16'h2);
        chk("new_period", 16'(n), 16'h2);
    endtask

    task automatic t_wake;
        int n;
        n = 0;
        @(posedge clk_i);
        wake_i <= 1'b1;
        @(posedge clk_i);
        wake_i <= 1'b0;
        repeat (20) begin
            #1;
            n += (ready !== 1'b1);
            @(posedge clk_i);
        end
        chk("wake_delay", 16'(n), 16'h6);
    endtask

    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        wake_i = 1'b0;
        want_pll = 1'b0;
        watch = 1'b0;
        bus_i = '0;
        cfg = '0;
        errors = 0;
        samples_checked = 0;
        cycles = 0;
        gap = 0;
        min_gap = 999;
        t_startup();
        t_pll();
        t_pll_source();
        t_divider();
        t_protect();
        t_glitch();
        t_wake();
        test_done();
    end
endmodule

`default_nettype wire
